// file: src/dacc_defines.svh
/*
 * Constants of the accumulator datapath: widths, field positions, saturation
 * and rounding values, write-back pointer step, shifter limit.
 * Assumes nothing; included by the package and the datapath module.
 */
`ifndef DACC_DEFINES_SVH
`define DACC_DEFINES_SVH

`define DACC_ACC_W          40
`define DACC_WORD_W         16
// core configuration register bit positions
`define DACC_CFG_SAT_A      7
`define DACC_CFG_SAT_B      6
`define DACC_CFG_SAT_MODE   4
`define DACC_CFG_WSAT       5
`define DACC_CFG_ROUND      1
// accumulator saturation values
`define DACC_MAX_POS_40     40'h7fffffffff
`define DACC_MAX_NEG_40     40'h8000000000
`define DACC_MAX_POS_32     40'h007fffffff
`define DACC_MAX_NEG_32     40'hff80000000
// round and data write saturation
`define DACC_RND_HALF       16'h8000
`define DACC_WSAT_POS       16'h7fff
`define DACC_WSAT_NEG       16'h8000
// write-back pointer step for a word write
`define DACC_WB_STEP        16'h0002
// shifter magnitude limit
`define DACC_SHIFT_MAX      16
// reset values
`define DACC_ACC_RST        40'h0000000000
`define DACC_PTR_RST        16'h0000

`endif

// file: src/dacc_pkg.sv
/*
 * Types carried by the ports of the accumulator datapath.
 * Assumes the constants header is in the include path.
 */
`include "dacc_defines.svh"

package dacc_pkg;

	typedef enum logic [2:0] {
		KIND_MULTIPLY_ACC,
		KIND_MULTIPLY_SUB,
		KIND_MOVE_STORE,
		KIND_CLEAR,
		KIND_MULTIPLY,
		KIND_NEG_MULTIPLY,
		KIND_DIST_SQ,
		KIND_DIST_SQ_ACC
	} dacc_kind_t;

	typedef enum logic [1:0] {
		SRC_ACC_A,
		SRC_ACC_B,
		SRC_XBUS
	} dacc_src_t;

	// adder operation; acc_sel 0 = A, 1 = B
	typedef struct packed {
		logic                    valid;
		logic                    acc_sel;
		logic                    subtract;
		logic                    zero_acc;
		logic                    carry_in;
		logic [`DACC_ACC_W-1:0]  operand;
	} dacc_op_t;

	typedef struct packed {
		logic acc_a_overflow_trap_en;
		logic acc_b_overflow_trap_en;
		logic catastrophic_trap_en;
	} dacc_trap_en_t;

	typedef struct packed {
		logic acc_a_guard_overflow;
		logic acc_b_guard_overflow;
		logic acc_a_saturated;
		logic acc_b_saturated;
		logic any_guard_overflow;
		logic any_saturated;
	} dacc_flags_t;

	typedef struct packed {
		logic valid;
		logic acc_sel;
		logic rounded;
	} dacc_store_t;

	typedef struct packed {
		logic       valid;
		dacc_kind_t kind;
		logic       indirect;
	} dacc_wb_t;

	typedef struct packed {
		logic                    valid;
		dacc_src_t               src;
		logic signed [5:0]       amount;
		logic                    arith;
		logic [`DACC_WORD_W-1:0] xdata;
	} dacc_shift_t;

endpackage : dacc_pkg

// file: src/dacc_datapath.sv
/*
 * Accumulator back end: 40-bit adder/subtracter with overflow, saturation and
 * sticky flags, trap request, round and data write saturation for stores and
 * write-back, write-back pointer, and a signed-amount barrel shifter.
 * Assumes all request inputs come from core logic in the clk_i domain (no
 * synchronisers) and that only one accumulator is targeted per operation.
 */
// Overview of operation
// - adder adds true data, subtracts complemented data
// - guard flag updates each op, bits 32-39
// - bit 39 sign overflow means catastrophic overflow
// - guard flag plus enable raises trap
// - saturated flags sticky, cleared only by software
// - unsaturated: flag records bit 39 overflow, trap
// - combined overflow and saturation OR bits
// - config bits 7:6 and 4 select saturation
// - 40-bit mode loads 9.31 extremes, sets flag
// - 32-bit mode loads 1.31 extremes, no guard
// - catastrophic mode wraps, sets flag, traps
// - multiply-accumulate class, except multiply, negated multiply and both distance kinds, writes back non-target high word
// - write-back direct to pointer or indirect +2
// - round stage yields 1.15, else truncate
// - conventional round increments for low >= 8000
// - convergent: at exactly 8000 use bit 16
// - store truncated or rounded; write-back rounded
// - write saturation clamps to 7fff or 8000
// - without write saturation data passes unchanged
// - one-cycle shift up to 16 either way
// - signed amount: positive right, negative left
// - 40-bit shifter, X bus placement by direction
`timescale 1ns/1ps
`include "dacc_defines.svh"

module dacc_datapath #(
	parameter int SHIFT_LIMIT = `DACC_SHIFT_MAX
) (
	// clock, reset, enable
	input  wire logic                     clk_i,
	input  wire logic                     sys_rst_i,
	input  wire logic                     ce_i,
	// configuration and software control
	input  wire logic [15:0]              core_config_reg_i,
	input  wire dacc_pkg::dacc_trap_en_t  trap_en_i,
	input  wire logic [1:0]               sat_clear_i,
	// requests
	input  wire dacc_pkg::dacc_op_t       op_i,
	input  wire dacc_pkg::dacc_store_t    store_i,
	input  wire dacc_pkg::dacc_wb_t       wb_i,
	input  wire logic                     ptr_load_i,
	input  wire logic [15:0]              ptr_data_i,
	input  wire dacc_pkg::dacc_shift_t    shift_i,
	// accumulators and status
	output logic [`DACC_ACC_W-1:0]        acc_a_o,
	output logic [`DACC_ACC_W-1:0]        acc_b_o,
	output dacc_pkg::dacc_flags_t         flags_o,
	output logic                          arith_trap_o,
	// store and write-back
	output logic                          store_valid_o,
	output logic [15:0]                   store_data_o,
	output logic                          wb_valid_o,
	output logic [15:0]                   wb_addr_o,
	output logic [15:0]                   wb_data_o,
	output logic [15:0]                   writeback_pointer_reg_o,
	// shifter
	output logic                          shift_valid_o,
	output logic [`DACC_ACC_W-1:0]        shift_result_o,
	output logic [15:0]                   shift_word_o
);
	import dacc_pkg::*;

	if (SHIFT_LIMIT < 1 || SHIFT_LIMIT > `DACC_SHIFT_MAX) begin : g_bad_limit
		$error("SHIFT_LIMIT must lie in 1..16");
	end

	// round, then optionally saturate to 1.15; sign taken from bit 39
	function automatic logic [15:0] dacc_round_word(input logic [39:0] acc, input logic rounding,
		input logic conv, input logic wsat);
		logic        inc;
		logic [24:0] hi;
		inc = rounding & acc[15];
		if (conv && acc[15:0] == `DACC_RND_HALF) begin
			inc = rounding & acc[16];
		end
		hi = {acc[39], acc[39:16]} + {24'h000000, inc};
		if (wsat && !acc[39] && hi[24:15] != 10'h000) begin
			return `DACC_WSAT_POS;
		end
		if (wsat && acc[39] && hi[24:15] != 10'h3ff) begin
			return `DACC_WSAT_NEG;
		end
		return hi[15:0];
	endfunction : dacc_round_word

	logic [`DACC_ACC_W-1:0] acc [2];
	logic [1:0]             guard;
	logic [1:0]             sat;
	logic                   trap;
	logic [`DACC_ACC_W-1:0] next_acc [2];
	logic [1:0]             next_guard;
	logic [1:0]             next_sat;
	logic                   next_trap;

	logic [`DACC_ACC_W-1:0] acc_in;
	logic [`DACC_ACC_W-1:0] b_in;
	logic [`DACC_ACC_W:0]   sum;
	logic [`DACC_ACC_W-1:0] res;
	logic                   cat_ovf;
	logic                   true_neg;
	logic                   guard_ovf;
	logic                   ovf31;
	logic [1:0]             sat_en;
	logic                   mode32;
	logic [1:0]             set_sat;

	assign sat_en = {core_config_reg_i[`DACC_CFG_SAT_B], core_config_reg_i[`DACC_CFG_SAT_A]};
	assign mode32 = core_config_reg_i[`DACC_CFG_SAT_MODE];

	// zero may replace the accumulator operand; borrow is active low
	assign acc_in    = op_i.zero_acc ? `DACC_ACC_RST : acc[op_i.acc_sel];
	assign b_in      = op_i.subtract ? ~op_i.operand : op_i.operand;
	assign sum       = {1'b0, acc_in} + {1'b0, b_in} + {40'h0000000000, op_i.carry_in};
	assign res       = sum[`DACC_ACC_W-1:0];
	// same-sign operands giving an opposite-sign result: sign lost
	assign cat_ovf   = (acc_in[39] == b_in[39]) && (res[39] != acc_in[39]);
	assign true_neg  = cat_ovf ? acc_in[39] : res[39];
	assign guard_ovf = (res[39:32] != 8'h00) && (res[39:32] != 8'hff);
	assign ovf31     = cat_ovf || ((res[39:31] != 9'h000) && (res[39:31] != 9'h1ff));

	always_comb begin
		next_acc[0] = acc[0];
		next_acc[1] = acc[1];
		next_guard  = guard;
		set_sat     = 2'b00;
		next_trap   = 1'b0;
		if (op_i.valid) begin
			next_acc[op_i.acc_sel]   = res;
			next_guard[op_i.acc_sel] = guard_ovf;
			next_trap = guard_ovf & (op_i.acc_sel ? trap_en_i.acc_b_overflow_trap_en
				: trap_en_i.acc_a_overflow_trap_en);
			if (sat_en[op_i.acc_sel] && !mode32) begin
				if (cat_ovf) begin
					next_acc[op_i.acc_sel] = true_neg ? `DACC_MAX_NEG_40 : `DACC_MAX_POS_40;
					set_sat[op_i.acc_sel]  = 1'b1;
				end
			end else if (sat_en[op_i.acc_sel]) begin
				// guard bits unused in 32-bit mode, so neither flag nor trap
				next_guard[op_i.acc_sel] = 1'b0;
				next_trap = 1'b0;
				if (ovf31) begin
					next_acc[op_i.acc_sel] = true_neg ? `DACC_MAX_NEG_32 : `DACC_MAX_POS_32;
					set_sat[op_i.acc_sel]  = 1'b1;
				end
			end else begin
				set_sat[op_i.acc_sel] = cat_ovf;
				next_trap = next_trap | (cat_ovf & trap_en_i.catastrophic_trap_en);
			end
		end
		// a set in the clearing cycle wins
		next_sat = set_sat | (sat & ~sat_clear_i);
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			acc[0] <= `DACC_ACC_RST;
			acc[1] <= `DACC_ACC_RST;
			guard  <= 2'b00;
			sat    <= 2'b00;
			trap   <= 1'b0;
		end else if (ce_i) begin
			acc[0] <= next_acc[0];
			acc[1] <= next_acc[1];
			guard  <= next_guard;
			sat    <= next_sat;
			trap   <= next_trap;
		end
	end

	assign acc_a_o      = acc[0];
	assign acc_b_o      = acc[1];
	assign arith_trap_o = trap;
	assign flags_o      = '{acc_a_guard_overflow: guard[0], acc_b_guard_overflow: guard[1],
		acc_a_saturated: sat[0], acc_b_saturated: sat[1],
		any_guard_overflow: |guard, any_saturated: |sat};

	// store and write-back
	logic        wsat;
	logic        conv;
	logic        wb_fire;
	logic [15:0] wb_word;
	logic [15:0] ptr;
	logic        next_store_valid;
	logic [15:0] next_store_data;
	logic        next_wb_valid;
	logic [15:0] next_wb_addr;
	logic [15:0] next_wb_data;
	logic [15:0] next_ptr;

	assign wsat    = core_config_reg_i[`DACC_CFG_WSAT];
	assign conv    = core_config_reg_i[`DACC_CFG_ROUND];
	assign wb_fire = wb_i.valid && !(wb_i.kind inside {KIND_MULTIPLY, KIND_NEG_MULTIPLY,
		KIND_DIST_SQ, KIND_DIST_SQ_ACC});
	// write-back always rounds the non-target accumulator
	assign wb_word = dacc_round_word(acc[~op_i.acc_sel], 1'b1, conv, wsat);

	always_comb begin
		next_store_valid = store_i.valid;
		next_store_data  = store_data_o;
		next_wb_valid    = wb_fire;
		next_wb_addr     = wb_addr_o;
		next_wb_data     = wb_data_o;
		next_ptr         = ptr_load_i ? ptr_data_i : ptr;
		if (store_i.valid) begin
			next_store_data = dacc_round_word(acc[store_i.acc_sel], store_i.rounded, conv, wsat);
		end
		if (wb_fire) begin
			next_wb_data = wb_word;
			if (wb_i.indirect) begin
				next_wb_addr = ptr;
				next_ptr     = ptr + `DACC_WB_STEP;
			end else begin
				next_wb_addr = ptr;
				next_ptr     = wb_word;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			store_valid_o <= 1'b0;
			store_data_o  <= 16'h0000;
			wb_valid_o    <= 1'b0;
			wb_addr_o     <= 16'h0000;
			wb_data_o     <= 16'h0000;
			ptr           <= `DACC_PTR_RST;
		end else if (ce_i) begin
			store_valid_o <= next_store_valid;
			store_data_o  <= next_store_data;
			wb_valid_o    <= next_wb_valid;
			wb_addr_o     <= next_wb_addr;
			wb_data_o     <= next_wb_data;
			ptr           <= next_ptr;
		end
	end

	assign writeback_pointer_reg_o = ptr;

	// barrel shifter; amounts beyond the limit are clamped to it
	logic [`DACC_ACC_W-1:0] sh_src;
	logic [5:0]             sh_mag;
	logic                   sh_left;
	logic [`DACC_ACC_W-1:0] sh_out;
	logic                   next_shift_valid;
	logic [`DACC_ACC_W-1:0] next_shift_result;
	logic [15:0]            next_shift_word;

	always_comb begin
		sh_left = shift_i.amount < 0;
		sh_mag  = sh_left ? 6'(-shift_i.amount) : 6'(shift_i.amount);
		if (sh_mag > 6'(SHIFT_LIMIT)) begin
			sh_mag = 6'(SHIFT_LIMIT);
		end
		case (shift_i.src)
			SRC_ACC_A: sh_src = acc[0];
			SRC_ACC_B: sh_src = acc[1];
			SRC_XBUS: begin
				if (sh_left) begin
					sh_src = {24'h000000, shift_i.xdata};
				end else begin
					sh_src = {{8{shift_i.arith & shift_i.xdata[15]}}, shift_i.xdata, 16'h0000};
				end
			end
			default: sh_src = `DACC_ACC_RST;
		endcase
		if (sh_left) begin
			sh_out = sh_src << sh_mag;
		end else if (shift_i.arith) begin
			sh_out = $unsigned($signed(sh_src) >>> sh_mag);
		end else begin
			sh_out = sh_src >> sh_mag;
		end
		next_shift_valid  = shift_i.valid;
		next_shift_result = shift_i.valid ? sh_out : shift_result_o;
		next_shift_word   = shift_word_o;
		if (shift_i.valid) begin
			next_shift_word = sh_left ? sh_out[15:0] : sh_out[31:16];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			shift_valid_o  <= 1'b0;
			shift_result_o <= `DACC_ACC_RST;
			shift_word_o   <= 16'h0000;
		end else if (ce_i) begin
			shift_valid_o  <= next_shift_valid;
			shift_result_o <= next_shift_result;
			shift_word_o   <= next_shift_word;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_sat_sticky_a: assert property (ce_i && sat[0] && !sat_clear_i[0] |=> sat[0])
		else $error("saturated flag A dropped without a clear");
	a_guard_trap: assert property (ce_i && op_i.valid && !op_i.acc_sel && guard_ovf && !mode32
		&& trap_en_i.acc_a_overflow_trap_en |=> arith_trap_o && guard[0])
		else $error("guard overflow with enable raised no trap");
	a_mode32_guard: assert property (ce_i && op_i.valid && sat_en[op_i.acc_sel] && mode32
		|=> !guard[$past(op_i.acc_sel)] && !arith_trap_o)
		else $error("guard flag or trap raised in 32-bit saturation mode");
	a_super_sat: assert property (ce_i && op_i.valid && !op_i.acc_sel && sat_en[0] && !mode32 && cat_ovf
		|=> (acc[0] == `DACC_MAX_POS_40 || acc[0] == `DACC_MAX_NEG_40) && sat[0])
		else $error("super saturation did not clamp accumulator A");
	a_wrap_catastr: assert property (ce_i && op_i.valid && op_i.acc_sel && !sat_en[1] && cat_ovf
		|=> acc[1] == $past(res) && sat[1] && flags_o.any_saturated)
		else $error("catastrophic overflow did not wrap and flag");
	a_wb_excluded: assert property (ce_i && wb_i.valid && wb_i.kind == KIND_DIST_SQ |=> !wb_valid_o)
		else $error("write-back issued for an excluded operation");
	a_wb_ptr_step: assert property (ce_i && wb_fire && wb_i.indirect
		|=> wb_valid_o && wb_addr_o == $past(ptr) && ptr == $past(ptr) + 16'h0002)
		else $error("indirect write-back pointer step wrong");
	a_wsat_clamp: assert property (ce_i && store_i.valid && wsat && !acc[store_i.acc_sel][39]
		&& acc[store_i.acc_sel][38:31] != 8'h00 |=> store_data_o == 16'h7fff)
		else $error("write saturation did not clamp positive store");
	a_shift_zero: assert property (ce_i && shift_i.valid && shift_i.amount == 6'sd0
		&& shift_i.src == SRC_ACC_B |=> shift_result_o == $past(acc[1]))
		else $error("zero shift changed the operand");

endmodule : dacc_datapath

// file: verif/dacc_xmem_model.sv
/* X bus data space model: keeps every write-back word by address.
   Assumes writes come as one-cycle valid strobes in the clk_i domain. */
`timescale 1ns/1ps
module dacc_xmem_model (
	// x bus write side
	input  wire logic        clk_i,
	input  wire logic        wr_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] data_i
);
	logic [15:0] mem [logic [15:0]];
	always @(posedge clk_i) begin
		if (wr_i) begin
			mem[addr_i] = data_i;
		end
	end
	// unwritten words read as the inverted address, so a missed write never looks right
	function automatic logic [15:0] rd(input logic [15:0] a);
		return mem.exists(a) ? mem[a] : ~a;
	endfunction : rd
endmodule : dacc_xmem_model

// file: verif/dsp_accumulator_datapath_tb_top.sv
/* Bench of the accumulator datapath: drives ops, stores, write-backs and
   shifts, queues expected results, compares them as outputs appear.
   Assumes the package and constants header are compiled first. */
`timescale 1ns/1ps
module dsp_accumulator_datapath_tb_top;
	import dacc_pkg::*;
	logic          clk_i = 1'b0, sys_rst_i = 1'b1, pld = 1'b0, acc_due = 1'b0, ce = 1'b1;
	logic [15:0]   cfg = '0, pdat = '0, ptr = '0;
	dacc_trap_en_t ten = '0;
	logic [1:0]    sclr = '0;
	dacc_op_t      op = '0;
	dacc_store_t   st = '0;
	dacc_wb_t      wb = '0;
	dacc_shift_t   sh = '0;
	dacc_flags_t   flg;
	logic [39:0]   acc_a, acc_b, sres, ma = '0, mb = '0;
	logic          trap, sv, wv, shv, ga = 0, gb = 0, sat_a = 0, sat_b = 0;
	logic [15:0]   sd, wa, wd, wp, sw;
	logic [86:0]   q_acc[$];
	logic [15:0]   q_st[$];
	logic [47:0]   q_wb[$];
	logic [55:0]   q_sh[$];
	int            n_errors = 0, samples_checked = 0;
	localparam logic [15:0] MODES[3] = '{16'h0000, 16'h00c0, 16'h00d0};
	localparam logic [39:0] SV[8] = '{40'h0012348000, 40'h0012358000, 40'h001234ffff, 40'h0012347fff,
		40'h007fff8000, 40'h0100000000, 40'hff00000000, 40'hff80000000};
	always #12.5 clk_i = ~clk_i;
	dacc_datapath uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .core_config_reg_i(cfg),
		.trap_en_i(ten), .sat_clear_i(sclr), .op_i(op), .store_i(st), .wb_i(wb), .ptr_load_i(pld),
		.ptr_data_i(pdat), .shift_i(sh), .acc_a_o(acc_a), .acc_b_o(acc_b), .flags_o(flg),
		.arith_trap_o(trap), .store_valid_o(sv), .store_data_o(sd), .wb_valid_o(wv), .wb_addr_o(wa),
		.wb_data_o(wd), .writeback_pointer_reg_o(wp), .shift_valid_o(shv), .shift_result_o(sres),
		.shift_word_o(sw));
	dacc_xmem_model u_mem (.clk_i(clk_i), .wr_i(wv), .addr_i(wa), .data_i(wd));
	task automatic chk_acc(string n, logic [39:0] e, logic [39:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk_acc
	task automatic chk_word(string n, logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk_word
	function automatic logic [15:0] word(logic [39:0] x, logic rounding);
		logic [24:0] h;
		logic        inc;
		inc = rounding & x[15];
		if (rounding && cfg[1] && x[15:0] == 16'h8000) inc = x[16];
		h = {x[39], x[39:16]} + 25'(inc);
		if (cfg[5] && !x[39] && h[24:15] != 10'h0) return 16'h7fff;
		if (cfg[5] && x[39] && h[24:15] != 10'h3ff) return 16'h8000;
		return h[15:0];
	endfunction : word
	task automatic do_op(logic s, logic sub, logic z, logic ci, logic [39:0] v);
		logic [39:0] a, b, r;
		logic        ov, g, se, o32, sg, tr;
		@(posedge clk_i);
		a = z ? 40'h0 : (s ? mb : ma);
		b = sub ? ~v : v;
		r = a + b + 40'(ci);
		ov = (a[39] == b[39]) && (r[39] != a[39]);
		g = !(&r[39:32] || !(|r[39:32]));
		se = s ? cfg[6] : cfg[7];
		sg = ov ? a[39] : r[39];
		o32 = ov || !(&r[39:31] || !(|r[39:31]));
		if (se && cfg[4]) begin
			g = 1'b0;
			if (o32) r = sg ? 40'hff80000000 : 40'h007fffffff;
		end else if (se && ov) r = sg ? 40'h8000000000 : 40'h7fffffffff;
		tr = (g && (s ? ten.acc_b_overflow_trap_en : ten.acc_a_overflow_trap_en))
			|| (!se && ov && ten.catastrophic_trap_en);
		if (s) begin
			mb = r;
			gb = g;
			sat_b |= (se && cfg[4]) ? o32 : ov;
		end else begin
			ma = r;
			ga = g;
			sat_a |= (se && cfg[4]) ? o32 : ov;
		end
		q_acc.push_back({ma, mb, ga, gb, sat_a, sat_b, ga | gb, sat_a | sat_b, tr});
		op <= '{1'b1, s, sub, z, ci, v};
		@(posedge clk_i);
		op.valid <= 1'b0;
	endtask : do_op
	task automatic do_st(logic s, logic rounding);
		@(posedge clk_i);
		q_st.push_back(word(s ? mb : ma, rounding));
		st <= '{1'b1, s, rounding};
		@(posedge clk_i);
		st.valid <= 1'b0;
	endtask : do_st
	task automatic do_wb(dacc_kind_t k, logic ind, logic s);
		logic [15:0] w;
		@(posedge clk_i);
		w = word(s ? ma : mb, 1'b1);
		if (!(k inside {KIND_MULTIPLY, KIND_NEG_MULTIPLY, KIND_DIST_SQ, KIND_DIST_SQ_ACC})) begin
			q_wb.push_back({ptr, w, ind ? ptr + 16'h2 : w});
			ptr = ind ? ptr + 16'h2 : w;
		end
		op.acc_sel <= s;
		wb <= '{1'b1, k, ind};
		@(posedge clk_i);
		wb.valid <= 1'b0;
	endtask : do_wb
	task automatic do_sh(dacc_src_t src, logic signed [5:0] amt, logic ar, logic [15:0] x);
		logic [39:0] o, r;
		int          n;
		@(posedge clk_i);
		n = amt > 16 ? 16 : (amt < -16 ? -16 : int'(amt));
		if (src == SRC_XBUS) o = n >= 0 ? {{8{ar & x[15]}}, x, 16'h0} : {24'h0, x};
		else o = src == SRC_ACC_B ? mb : ma;
		if (n < 0) r = o << (-n);
		else if (ar) r = $signed(o) >>> n;
		else r = o >> n;
		q_sh.push_back({r, n >= 0 ? r[31:16] : r[15:0]});
		sh <= '{1'b1, src, amt, ar, x};
		@(posedge clk_i);
		sh.valid <= 1'b0;
	endtask : do_sh
	task automatic strobe_ctl(logic ld);
		@(posedge clk_i);
		if (ld) pld <= 1'b1;
		else sclr <= 2'b11;
		@(posedge clk_i);
		pld <= 1'b0;
		sclr <= 2'b00;
	endtask : strobe_ctl
	always @(posedge clk_i) acc_due <= op.valid & ~sys_rst_i;
	always @(negedge clk_i) begin
		logic [86:0] e;
		logic [47:0] w;
		logic [55:0] s;
		if (acc_due) begin
			e = q_acc.size() ? q_acc.pop_front() : 'x;
			chk_acc("acc_a", e[86:47], acc_a);
			chk_acc("acc_b", e[46:7], acc_b);
			chk_word("flags", {10'h0, e[6:1]}, {10'h0, flg});
			chk_word("trap", {15'h0, e[0]}, {15'h0, trap});
		end
		if (sv) chk_word("store", q_st.size() ? q_st.pop_front() : 'x, sd);
		if (wv) begin
			w = q_wb.size() ? q_wb.pop_front() : 'x;
			chk_word("wb_addr", w[47:32], wa);
			chk_word("wb_data", w[31:16], wd);
			chk_word("wb_ptr", w[15:0], wp);
		end
		if (shv) begin
			s = q_sh.size() ? q_sh.pop_front() : 'x;
			chk_acc("shift", s[55:16], sres);
			chk_word("shift_word", s[15:0], sw);
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (6000) @(posedge clk_i);
		n_errors++;
		test_done();
	end
	initial begin
		logic [31:0] x;
		void'($urandom(32'h108daacb));
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		repeat (24) begin
			x = $urandom;
			ten <= x[8:6];
			do_op(x[0], x[1], &x[4:2], x[5], {{8{x[31]}}, x});
		end
		$display("test add_sub done");
		foreach (MODES[i]) begin
			cfg <= MODES[i];
			ten <= 3'b111;
			do_op(0, 0, 1, 0, 40'h7ffffffff0);
			do_op(0, 0, 0, 0, 40'h20);
			do_op(1, 0, 1, 0, 40'h8000000010);
			do_op(1, 1, 0, 1, 40'h20);
			do_op(0, 0, 1, 0, 40'h007fffffff);
			do_op(0, 0, 0, 1, 40'h0);
			do_op(0, 0, 0, 0, 40'h0100000000);
			strobe_ctl(1'b0);
			sat_a = 1'b0;
			sat_b = 1'b0;
			do_op(1, 0, 0, 0, 40'h0);
		end
		$display("test sat_modes done");
		foreach (SV[i]) begin
			do_op(i[0], 0, 1, 0, SV[i]);
			for (int c = 0; c < 4; c++) begin
				cfg <= {10'h0, c[1], 3'h0, c[0], 1'b0};
				do_st(i[0], 0);
				do_st(i[0], 1);
			end
		end
		$display("test store done");
		cfg <= 16'h0022;
		do_op(0, 0, 1, 0, 40'h0012348000);
		do_op(1, 0, 1, 0, 40'hff00000000);
		pdat <= 16'h1000;
		ptr = 16'h1000;
		strobe_ctl(1'b1);
		for (int k = 0; k < 8; k++) do_wb(dacc_kind_t'(k), 1'b1, k[0]);
		do_wb(KIND_CLEAR, 1'b0, 1'b1);
		do_wb(KIND_MOVE_STORE, 1'b1, 1'b0);
		repeat (3) @(posedge clk_i);
		chk_word("xmem", word(ma, 1'b1), u_mem.rd(16'h1002));
		chk_word("xmem", word(mb, 1'b1), u_mem.rd(ptr - 16'h2));
		$display("test write_back done");
		// wrap A first to set its saturated flag, so a refused clear while frozen is visible
		do_op(0, 0, 0, 0, 40'h7fffffffff);
		ce <= 1'b0;
		pdat <= 16'h0abc;
		strobe_ctl(1'b1);
		strobe_ctl(1'b0);
		ce <= 1'b1;
		@(negedge clk_i);
		chk_word("frozen_ptr", ptr, wp);
		chk_word("frozen_flags", {10'h0, ga, gb, sat_a, sat_b, ga | gb, sat_a | sat_b}, {10'h0, flg});
		$display("test clock_enable done");
		for (int n = -18; n <= 18; n++) begin
			x = $urandom;
			do_sh(dacc_src_t'(x[1:0] % 3), 6'(n), x[2], x[31:16]);
		end
		$display("test shift done");
		repeat (3) @(posedge clk_i);
		chk_word("pending", 16'h0, 16'(q_acc.size() + q_st.size() + q_wb.size() + q_sh.size()));
		test_done();
	end
endmodule : dsp_accumulator_datapath_tb_top
